// ---- hw/frbg_cfg.svh ----
/*
 Offsets, field positions, reset values and counts of the fractional rate generator.
 Assumes inclusion by bare name from any file that needs them.
*/
`ifndef FRBG_CFG_SVH
`define FRBG_CFG_SVH

// ----------------------------------------------------------------
// Map: channel window and register word offsets
// ----------------------------------------------------------------
`define FRBG_NUM_CH 8
`define FRBG_CH_LSB 5
`define FRBG_MAP_TOP_LSB 8
`define FRBG_OFF_DIV_LOW 12'h000
`define FRBG_OFF_DIV_HIGH 12'h004
`define FRBG_OFF_DIV_FRAC 12'h008
`define FRBG_OFF_EIGHT_X 12'h00c
`define FRBG_OFF_FOUR_X 12'h010
`define FRBG_OFF_MODEM_CTRL 12'h014
`define FRBG_OFF_STATUS 12'h018

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define FRBG_PRESCALE_BIT 7
`define FRBG_FRAC_W 4
`define FRBG_ST_MODE_LSB 0
`define FRBG_ST_EXT_BIT 4
`define FRBG_ST_ACC_LSB 8
`define FRBG_MODE_SET 8'hff
`define FRBG_MODE_CLR 8'h00

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FRBG_RST_DIV_LOW 8'h01
`define FRBG_RST_DIV_HIGH 8'h00
`define FRBG_RST_DIV_FRAC 8'h00
`define FRBG_RST_MODE 8'h00
`define FRBG_RST_MODEM_CTRL 8'h00

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define FRBG_PRESCALE_LAST 2'h3
`define FRBG_SMP16_LAST 4'hf
`define FRBG_SMP8_LAST 4'h7
`define FRBG_SMP4_LAST 4'h3
`define FRBG_DIV_ZERO_AS 17'h10000

`endif

// ---- hw/frbg_pkg.sv ----
/*
 Types shared by the fractional rate generator.
 Writes its encodings out as literals and does not use frbg_cfg.svh.
*/
package frbg_pkg;

   // ----------------------------------------------------------------
   // Sampling modes and register selectors
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FRBG_SMP16 = 2'b00,
      FRBG_SMP8 = 2'b01,
      FRBG_SMP4 = 2'b10,
      FRBG_SMPRSV = 2'b11
   } frbg_mode_e;

   typedef enum logic [2:0] {
      FRBG_R_DLOW = 3'b000,
      FRBG_R_DHIGH = 3'b001,
      FRBG_R_DFRAC = 3'b010,
      FRBG_R_EIGHT = 3'b011,
      FRBG_R_FOUR = 3'b100,
      FRBG_R_MCTRL = 3'b101,
      FRBG_R_STAT = 3'b110,
      FRBG_R_NONE = 3'b111
   } frbg_reg_e;

endpackage

// ---- hw/frbg_top.sv ----
/*
 Eight-channel fractional rate generator with an APB register slave.
 Assumes pclk is the reference clock and that the serial logic consumes the ticks.
*/
// The address map and the APB register port were left to the implementer.
// Function
// - Each channel has its own prescaler and rate generator for its transmitter and receiver.
// - The one reference clock drives all channel generators and the rest of the logic.
// - Modem-control bit 7 clear passes the reference clock, set divides it by four first.
// - The generator divides the prescaled clock by 1 up to 65536 and 15/16 in 1/16 steps.
// - The output is a 16x, 8x or 4x sampling tick used to shift and to sample bits.
// - Reset loads the low divisor byte with 0x01 and the high byte and fraction with 0x00.
// - The integer divisor is the high byte in bits 15:8 and the low byte in bits 7:0.
// - Only the low four fraction bits exist and give the fraction in sixteenths.
// - Two 8-bit mode registers pick 16x, 8x or 4x sampling, both set being reserved.
// - In 8x mode an odd non-zero fraction lets the bit time jitter by one sixteenth.
`timescale 1ns/1ps
`include "frbg_cfg.svh"

module frbg_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Per-channel sampling and bit ticks
   output logic [7:0] sample_tick,
   output logic [7:0] bit_tick
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Only aligned words of a channel window decode; anything else is answered with an error.
   function automatic frbg_pkg::frbg_reg_e reg_sel(input logic [11:0] a);
      frbg_pkg::frbg_reg_e r;
      r = frbg_pkg::FRBG_R_NONE;
      if (a[11:`FRBG_MAP_TOP_LSB] == 4'h0) begin
         unique case ({7'h00, a[4:0]})
            `FRBG_OFF_DIV_LOW: r = frbg_pkg::FRBG_R_DLOW;
            `FRBG_OFF_DIV_HIGH: r = frbg_pkg::FRBG_R_DHIGH;
            `FRBG_OFF_DIV_FRAC: r = frbg_pkg::FRBG_R_DFRAC;
            `FRBG_OFF_EIGHT_X: r = frbg_pkg::FRBG_R_EIGHT;
            `FRBG_OFF_FOUR_X: r = frbg_pkg::FRBG_R_FOUR;
            `FRBG_OFF_MODEM_CTRL: r = frbg_pkg::FRBG_R_MCTRL;
            `FRBG_OFF_STATUS: r = frbg_pkg::FRBG_R_STAT;
            default: r = frbg_pkg::FRBG_R_NONE;
         endcase
      end
      return r;
   endfunction

   // A select that is neither all ones nor all zeros forces 16x sampling, whatever the other select holds.
   function automatic frbg_pkg::frbg_mode_e mode_of(input logic [7:0] e8,
                                                    input logic [7:0] e4);
      frbg_pkg::frbg_mode_e m;
      m = frbg_pkg::FRBG_SMP16;
      if (e8 == `FRBG_MODE_SET && e4 == `FRBG_MODE_SET) begin
         m = frbg_pkg::FRBG_SMPRSV;
      end else if (e8 == `FRBG_MODE_SET && e4 == `FRBG_MODE_CLR) begin
         m = frbg_pkg::FRBG_SMP8;
      end else if (e8 == `FRBG_MODE_CLR && e4 == `FRBG_MODE_SET) begin
         m = frbg_pkg::FRBG_SMP4;
      end
      return m;
   endfunction

   // ----------------------------------------------------------------
   // Register file, one set per channel
   // ----------------------------------------------------------------
   // Channel state lives in flip-flop arrays indexed by the channel field of the address.
   logic [7:0] dlow_q [8];
   logic [7:0] dlow_d [8];
   logic [7:0] dhigh_q [8];
   logic [7:0] dhigh_d [8];
   logic [3:0] dfrac_q [8];
   logic [3:0] dfrac_d [8];
   logic [7:0] eight_q [8];
   logic [7:0] eight_d [8];
   logic [7:0] four_q [8];
   logic [7:0] four_d [8];
   logic [7:0] mctrl_q [8];
   logic [7:0] mctrl_d [8];
   logic [31:0] stat_w [8];
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;

   frbg_pkg::frbg_reg_e sel;
   logic [2:0] ch;
   logic setup;
   logic wr_go;

   assign sel = reg_sel(paddr);
   assign ch = paddr[`FRBG_CH_LSB +: 3];
   assign setup = psel && !penable;
   assign wr_go = psel && penable && pready_q && pwrite;

   // ----------------------------------------------------------------
   // Bus answer, registered one cycle after setup
   // ----------------------------------------------------------------
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      // Answer is prepared in the setup cycle so the access phase needs no wait.
      pready_d = setup;
      if (setup) begin
         pslverr_d = (sel == frbg_pkg::FRBG_R_NONE);
         unique case (sel)
            frbg_pkg::FRBG_R_DLOW: prdata_d = {24'h000000, dlow_q[ch]};
            frbg_pkg::FRBG_R_DHIGH: prdata_d = {24'h000000, dhigh_q[ch]};
            frbg_pkg::FRBG_R_DFRAC: prdata_d = {28'h0000000, dfrac_q[ch]};
            frbg_pkg::FRBG_R_EIGHT: prdata_d = {24'h000000, eight_q[ch]};
            frbg_pkg::FRBG_R_FOUR: prdata_d = {24'h000000, four_q[ch]};
            frbg_pkg::FRBG_R_MCTRL: prdata_d = {24'h000000, mctrl_q[ch]};
            frbg_pkg::FRBG_R_STAT: prdata_d = stat_w[ch];
            frbg_pkg::FRBG_R_NONE: prdata_d = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register writes, taken at the access edge
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < `FRBG_NUM_CH; i++) begin
         dlow_d[i] = dlow_q[i];
         dhigh_d[i] = dhigh_q[i];
         dfrac_d[i] = dfrac_q[i];
         eight_d[i] = eight_q[i];
         four_d[i] = four_q[i];
         mctrl_d[i] = mctrl_q[i];
      end
      if (wr_go) begin
         unique case (sel)
            frbg_pkg::FRBG_R_DLOW: dlow_d[ch] = pwdata[7:0];
            frbg_pkg::FRBG_R_DHIGH: dhigh_d[ch] = pwdata[7:0];
            frbg_pkg::FRBG_R_DFRAC: dfrac_d[ch] = pwdata[3:0];
            frbg_pkg::FRBG_R_EIGHT: eight_d[ch] = pwdata[7:0];
            frbg_pkg::FRBG_R_FOUR: four_d[ch] = pwdata[7:0];
            frbg_pkg::FRBG_R_MCTRL: mctrl_d[ch] = pwdata[7:0];
            // Status is read-only, so a write to it, like one to a hole, changes nothing.
            frbg_pkg::FRBG_R_STAT: dlow_d[ch] = dlow_q[ch];
            frbg_pkg::FRBG_R_NONE: dlow_d[ch] = dlow_q[ch];
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `FRBG_NUM_CH; i++) begin
            dlow_q[i] <= `FRBG_RST_DIV_LOW;
            dhigh_q[i] <= `FRBG_RST_DIV_HIGH;
            dfrac_q[i] <= 4'(`FRBG_RST_DIV_FRAC);
            eight_q[i] <= `FRBG_RST_MODE;
            four_q[i] <= `FRBG_RST_MODE;
            mctrl_q[i] <= `FRBG_RST_MODEM_CTRL;
         end
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         for (int i = 0; i < `FRBG_NUM_CH; i++) begin
            dlow_q[i] <= dlow_d[i];
            dhigh_q[i] <= dhigh_d[i];
            dfrac_q[i] <= dfrac_d[i];
            eight_q[i] <= eight_d[i];
            four_q[i] <= four_d[i];
            mctrl_q[i] <= mctrl_d[i];
         end
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------------------------------
   // Bus outputs, straight from their flip-flops
   // ----------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------
   // Channel generators, all on the one reference clock
   // ----------------------------------------------------------------
   for (genvar g = 0; g < `FRBG_NUM_CH; g++) begin : gen_ch
      logic [1:0] pre_q;
      logic [1:0] pre_d;
      logic [16:0] cnt_q;
      logic [16:0] cnt_d;
      logic [3:0] acc_q;
      logic [3:0] acc_d;
      logic ext_q;
      logic ext_d;
      logic tick_q;
      logic tick_d;
      logic [3:0] smp_q;
      logic [3:0] smp_d;
      logic bit_q;
      logic bit_d;
      logic pre_tick;
      logic [16:0] div_int;
      logic [16:0] last;
      logic [4:0] acc_sum;
      logic [3:0] smp_last;
      frbg_pkg::frbg_mode_e mode;

      assign mode = mode_of(eight_q[g], four_q[g]);
      // A zero integer acts as the largest divisor rather than stalling the channel.
      assign div_int = ({dhigh_q[g], dlow_q[g]} == 16'h0000) ? `FRBG_DIV_ZERO_AS
                       : {1'b0, dhigh_q[g], dlow_q[g]};
      // The carry of the previous period stretches this one by one prescaled clock.
      assign last = div_int - 17'h00001 + {16'h0000, ext_q};
      assign acc_sum = {1'b0, acc_q} + {1'b0, dfrac_q[g]};
      assign stat_w[g] = {20'h00000, acc_q, 3'b000, ext_q, 2'b00, mode};

      always_comb begin
         // The prescaler runs free, so changing its ratio mid-period bends that one period.
         pre_d = pre_q + 2'h1;
         pre_tick = mctrl_q[g][`FRBG_PRESCALE_BIT] ? (pre_q == `FRBG_PRESCALE_LAST)
                    : 1'b1;
         cnt_d = cnt_q;
         acc_d = acc_q;
         ext_d = ext_q;
         tick_d = 1'b0;
         if (pre_tick) begin
            // Greater-or-equal lets a shrunken divisor take effect without wrapping.
            if (cnt_q >= last) begin
               cnt_d = 17'h00000;
               tick_d = 1'b1;
               acc_d = acc_sum[3:0];
               ext_d = acc_sum[4];
            end else begin
               cnt_d = cnt_q + 17'h00001;
            end
         end
      end

      // ----------------------------------------------------------------
      // Sampling and bit counters
      // ----------------------------------------------------------------
      always_comb begin
         unique case (mode)
            frbg_pkg::FRBG_SMP8: smp_last = `FRBG_SMP8_LAST;
            frbg_pkg::FRBG_SMP4: smp_last = `FRBG_SMP4_LAST;
            frbg_pkg::FRBG_SMP16: smp_last = `FRBG_SMP16_LAST;
            frbg_pkg::FRBG_SMPRSV: smp_last = `FRBG_SMP16_LAST;
         endcase
         smp_d = smp_q;
         bit_d = 1'b0;
         // With 8 ticks a bit, an odd fraction leaves the bit one sixteenth long or short.
         if (tick_d) begin
            if (smp_q >= smp_last) begin
               smp_d = 4'h0;
               bit_d = 1'b1;
            end else begin
               smp_d = smp_q + 4'h1;
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pre_q <= 2'h0;
            cnt_q <= 17'h00000;
            acc_q <= 4'h0;
            ext_q <= 1'b0;
            tick_q <= 1'b0;
            smp_q <= 4'h0;
            bit_q <= 1'b0;
         end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            ext_q <= ext_d;
            tick_q <= tick_d;
            smp_q <= smp_d;
            bit_q <= bit_d;
         end
      end

      // Both ticks leave straight from flip-flops; at divisor 1 without prescale the sample tick is high in back-to-back cycles.
      assign sample_tick[g] = tick_q;
      assign bit_tick[g] = bit_q;
   end

endmodule

// ---- tb/frbg_asserts.sv ----
/*
 Port assertions for the fractional rate generator.
 Assumes it is bound to frbg_top and sees only its ports.
*/
`timescale 1ns/1ps
module frbg_asserts (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Ticks
   input wire logic [7:0] sample_tick,
   input wire logic [7:0] bit_tick
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Channel 0 keeps 16x in the bench, so sixteen sample ticks bound a bit.
   logic [4:0] smp_q, smp_d;
   always_comb begin
      smp_d = smp_q;
      if (bit_tick[0])
         smp_d = 5'h00;
      else if (sample_tick[0])
         smp_d = smp_q + 5'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         smp_q <= 5'h00;
      else
         smp_q <= smp_d;
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   ready_after_setup_a: assert property (setup_s ##1 access_s |-> pready)
      else $error("no ready in the access cycle");
   ready_needs_access_a: assert property (pready |-> psel && penable)
      else $error("ready without an access");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   error_reads_zero_a: assert property (pslverr |-> prdata == 32'h0)
      else $error("error read not zero");
   unmapped_error_a: assert property (setup_s ##0 paddr[11:8] != 4'h0 |=> pslverr)
      else $error("unmapped access not refused");
   bit_on_sample_a: assert property ((bit_tick & ~sample_tick) == 8'h00)
      else $error("bit tick off a sample tick");
   bit_within_sixteen_a: assert property (
      sample_tick[0] && smp_q == 5'h0f |-> bit_tick[0])
      else $error("bit longer than sixteen samples");
endmodule
bind frbg_top frbg_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_tick(sample_tick), .bit_tick(bit_tick));

// ---- tb/testbench.sv ----
/*
 Self-checking bench for the eight-channel rate generator.
 Assumes frbg_top and its bound checker are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd, r;
   logic [7:0] sample_tick, bit_tick;
   logic [1:0] m;
   int mismatches, checks_done, span, k;
   // ----------------------------------------------------------------
   // Per test: divisor, fraction, selects and prescale
   // ----------------------------------------------------------------
   int dv[8] = '{2, 3, 261, 1, 6, 5, 4, 7};
   int fr[8] = '{0, 12, 1, 8, 11, 3, 5, 15};
   logic [7:0] s8[8] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h5a};
   logic [7:0] s4[8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
   bit pre[8] = '{0, 0, 0, 1, 0, 1, 1, 0};
   frbg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_tick(sample_tick), .bit_tick(bit_tick));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // An idle cycle follows each transfer so no strobe is driven twice in one step.
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The wait has no limit of its own; the watchdog ends a hang.
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 1, "bus answer");
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input int ch, input int off, input logic [31:0] exp);
      apb(1'b0, 12'(ch * 32 + off), 32'h0);
      chk({e, r}, {1'b0, exp}, "read data");
   endtask
   task automatic wr(input int ch, input int off, input logic [7:0] v);
      rnd = lfsr(rnd);
      apb(1'b1, 12'(ch * 32 + off), {rnd[23:0], v});
   endtask
   task automatic wait_tick(input int ch);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sample_tick[ch] !== 1'b1 && n < 6000);
      span += n;
   endtask
   task automatic measure(input int ch, input int per, input int bits);
      repeat (3) wait_tick(ch);
      span = 0;
      repeat (16) wait_tick(ch);
      chk(span, per, "sixteen periods");
      // The first pass aligns to a bit edge, the second counts one whole bit.
      repeat (2) begin
         k = 0;
         do begin
            wait_tick(ch);
            k++;
         end while (bit_tick[ch] !== 1'b1 && k < 40);
      end
      chk(k, bits, "samples per bit");
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rnd = 32'h0636f27e;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int c = 0; c < 8; c++) begin
         rd(c, 0, 32'h1);
         rd(c, 4, 32'h0);
         rd(c, 8, 32'h0);
         rd(c, 12, 32'h0);
         rd(c, 16, 32'h0);
         rd(c, 20, 32'h0);
      end
      $display("test reset values done");
      apb(1'b1, 12'h100, 32'h5a);
      chk(e, 1'b1, "unmapped write");
      apb(1'b0, 12'h01c, 32'h0);
      chk({e, r}, 33'h100000000, "unmapped read");
      rd(0, 0, 32'h1);
      $display("test unmapped done");
      for (int t = 0; t < 8; t++) begin
         wr(t, 0, 8'(dv[t]));
         wr(t, 4, 8'(dv[t] >> 8));
         wr(t, 8, {rnd[3:0], 4'(fr[t])});
         wr(t, 12, s8[t]);
         wr(t, 16, s4[t]);
         wr(t, 20, {pre[t], 7'h00});
         rd(t, 0, 32'(dv[t] & 255));
         rd(t, 4, 32'(dv[t] >> 8));
         rd(t, 8, 32'(fr[t]));
         rd(t, 20, {24'h0, pre[t], 7'h00});
         m = {s4[t] == 8'hff, s8[t] == 8'hff};
         apb(1'b0, 12'(t * 32 + 24), 32'h0);
         chk(r[1:0], m, "status mode");
         measure(t, (pre[t] ? 4 : 1) * (16 * dv[t] + fr[t]),
            (m == 2'd1) ? 8 : (m == 2'd2) ? 4 : 16);
         $display("test channel %0d rate done", t);
      end
      tally_and_finish();
   end
   initial begin
      repeat (50000) @(posedge pclk);
      mismatches++;
      tally_and_finish();
   end
endmodule
